// [verilog/sample_fifo_pkg.sv]
// Shared constants and carriers for the conversion-sample FIFO control block.
// Assumes one device clock; all users import the whole package.
package sample_fifo_pkg;

   // ----------------------------------------
   // Sizes
   // ----------------------------------------
   localparam int SAMPLE_W = 24;
   localparam int DEPTH = 256;
   localparam int PTR_W = 8;
   localparam int COUNT_W = 9;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int CTRL_W = 24;
   localparam int FLAG_W = 7;

   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [ADDR_W-1:0] CTRL_ADDR = 8'h3a;
   localparam logic [ADDR_W-1:0] FLAGS_ADDR = 8'h3b;
   localparam logic [ADDR_W-1:0] LEVEL_ADDR = 8'h3c;
   localparam logic [ADDR_W-1:0] SAMPLE_ADDR = 8'h3d;

   // ----------------------------------------
   // Control register fields
   // ----------------------------------------
   localparam int FILL_LSB = 0;
   localparam int FILL_W = 8;
   localparam int EMPTY_EN_BIT = 8;
   localparam int FILL_EN_BIT = 9;
   localparam int OVERRUN_EN_BIT = 10;
   localparam int LOWER_EN_BIT = 11;
   localparam int UPPER_EN_BIT = 12;
   localparam int READ_ERR_EN_BIT = 13;
   localparam int WRITE_ERR_EN_BIT = 14;
   localparam int SPARE_BIT = 15;
   localparam int MODE_LSB = 16;
   localparam int HEADER_BIT = 18;
   localparam int STATUS_ADD_BIT = 19;
   localparam int CTRL_RW_W = 20;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 24'h040200;

   // ----------------------------------------
   // Sticky flag positions, same order as the enables
   // ----------------------------------------
   localparam int EMPTY_FLAG = 0;
   localparam int FILL_FLAG = 1;
   localparam int OVERRUN_FLAG = 2;
   localparam int LOWER_FLAG = 3;
   localparam int UPPER_FLAG = 4;
   localparam int READ_ERR_FLAG = 5;
   localparam int WRITE_ERR_FLAG = 6;
   localparam logic [FLAG_W-1:0] FLAGS_RESET = 7'h00;

   // ----------------------------------------
   // Modes and carriers
   // ----------------------------------------
   localparam logic [1:0] MODE_OFF_CODE = 2'h0;
   localparam logic [1:0] MODE_FILL_CODE = 2'h1;

   typedef enum logic [1:0] {MODE_OFF, MODE_FILL_LIMITED, MODE_STREAMING} fifo_mode_e;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } bus_req_s;

   typedef struct packed {
      logic valid;
      logic [SAMPLE_W-1:0] data;
   } sample_s;

endpackage

// [verilog/sample_store.sv]
// Flip-flop sample storage with read and write pointers and an occupancy count.
// Assumes the caller never pushes into a full store without popping at once.
`timescale 1ns/1ps
module sample_store (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic flush_i,
   input wire logic push_i,
   input wire logic pop_i,
   input wire logic [sample_fifo_pkg::SAMPLE_W-1:0] push_data_i,
   output logic [sample_fifo_pkg::SAMPLE_W-1:0] head_o,
   output logic [sample_fifo_pkg::COUNT_W-1:0] count_o,
   output logic empty_o,
   output logic full_o
);
   import sample_fifo_pkg::*;

   logic [SAMPLE_W-1:0] store [DEPTH];
   logic [PTR_W-1:0] wr_ptr;
   logic [PTR_W-1:0] rd_ptr;
   logic [COUNT_W-1:0] count;
   logic [PTR_W-1:0] next_wr_ptr;
   logic [PTR_W-1:0] next_rd_ptr;
   logic [COUNT_W-1:0] next_count;
   logic do_push;
   logic do_pop;

   // ----------------------------------------
   // Pointers
   // ----------------------------------------
   assign empty_o = (count == '0);
   assign full_o = (count == COUNT_W'(DEPTH));
   assign do_pop = pop_i && !empty_o;
   // A push into a full store only lands when the oldest entry leaves together with it
   assign do_push = push_i && (!full_o || do_pop);

   always_comb begin
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count = count;
      if (flush_i) begin
         next_wr_ptr = '0;
         next_rd_ptr = '0;
         next_count = '0;
      end else begin
         if (do_push) begin
            next_wr_ptr = wr_ptr + 8'h01;
         end
         if (do_pop) begin
            next_rd_ptr = rd_ptr + 8'h01;
         end
         if (do_push && !do_pop) begin
            next_count = count + 9'h001;
         end else if (do_pop && !do_push) begin
            next_count = count - 9'h001;
         end
      end
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
      end
   end

   // ----------------------------------------
   // Storage
   // ----------------------------------------
   // No reset on the array: contents are never read before being written
   always_ff @(posedge clock_i) begin
      if (do_push && !flush_i) begin
         store[wr_ptr] <= push_data_i;
      end
   end

   assign head_o = store[rd_ptr];
   assign count_o = count;

endmodule // sample_store

// [verilog/sample_fifo_control_irq.sv]
// Control, discard policy, status flags and interrupt for the conversion-sample FIFO.
// Assumes samples arrive as one-cycle valid pulses and that software polls over the
// plain register port; the threshold comparators live outside and send event pulses.
`timescale 1ns/1ps

// Notes on behaviour
// RQ1 - Streaming full: drop oldest, keep newest
// RQ2 - Streaming drop sets the overrun flag
// RQ3 - Host writes zero to the spare bit
// RQ4 - Write-error enable gates write-error interrupt, resets 0
// RQ5 - Bit 13 enables read-error interrupt, resets 0
// RQ6 - Bit 12 enables upper-limit interrupt, resets 0
// RQ7 - Bit 11 enables lower-limit interrupt, resets 0
// RQ8 - Bit 10 enables overrun interrupt, resets 0
// RQ9 - Bit 9 enables fill-level interrupt, resets 1
// RQ10 - Empty interrupt rises with the empty flag
// RQ11 - Fill-level field: 0 means 256, else N
// RQ12 - Host avoids a fill level of one
// RQ13 - Mode field: off, fill-limited, streaming
// RQ14 - Fill-limited keeps first N, discards, flags overrun
// RQ15 - Write error clears once FIFO is empty
// RQ16 - Interrupt is OR of enabled set flags
module sample_fifo_control_irq (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire sample_fifo_pkg::bus_req_s bus_i,
   output logic [sample_fifo_pkg::DATA_W-1:0] rd_data_o,
   input wire sample_fifo_pkg::sample_s sample_i,
   input wire logic upper_limit_flag_i,
   input wire logic lower_limit_flag_i,
   output logic irq_o
);
   import sample_fifo_pkg::*;

   logic [CTRL_RW_W-1:0] ctrl;
   logic [FLAG_W-1:0] flags;
   logic [DATA_W-1:0] rd_data;
   logic [SAMPLE_W-1:0] last_sample;
   logic locked;
   logic was_empty;
   logic was_filled;
   logic [CTRL_RW_W-1:0] next_ctrl;
   logic [FLAG_W-1:0] next_flags;
   logic [DATA_W-1:0] next_rd_data;
   logic [SAMPLE_W-1:0] next_last_sample;
   logic next_locked;
   logic next_was_empty;
   logic next_was_filled;

   fifo_mode_e mode;
   logic [FILL_W-1:0] fill_field;
   logic [COUNT_W-1:0] fill_target;
   logic [SAMPLE_W-1:0] head;
   logic [COUNT_W-1:0] count;
   logic empty;
   logic full;
   logic push;
   logic pop;
   logic flush;
   logic fill_reached;
   logic sample_read;
   logic read_collide;
   logic limit_block;
   logic stream_drop;
   logic [FLAG_W-1:0] set_flags;
   logic [FLAG_W-1:0] clear_flags;
   logic [FLAG_W-1:0] enables;

   // ----------------------------------------
   // Mode and fill level decode
   // ----------------------------------------
   always_comb begin
      unique case (ctrl[MODE_LSB +: 2])
         MODE_OFF_CODE: mode = MODE_OFF; // RQ13
         MODE_FILL_CODE: mode = MODE_FILL_LIMITED; // RQ13
         default: mode = MODE_STREAMING; // RQ13
      endcase
   end

   assign fill_field = ctrl[FILL_LSB +: FILL_W];
   // A zero field stands for the whole depth
   assign fill_target = (fill_field == '0) ? COUNT_W'(DEPTH) : {1'b0, fill_field}; // RQ11
   assign fill_reached = (mode != MODE_OFF) && (count >= fill_target); // RQ11

   // ----------------------------------------
   // Write and read policy
   // ----------------------------------------
   assign sample_read = bus_i.rd && (bus_i.addr == SAMPLE_ADDR);
   assign flush = (mode == MODE_OFF);
   assign pop = sample_read && !flush && !empty;
   // A conversion landing during a sample read of a non-empty FIFO is not stored
   assign read_collide = sample_i.valid && pop;
   // Fill-limited mode stays closed from reaching the level until fully drained
   assign limit_block = (mode == MODE_FILL_LIMITED) && ((locked && !empty) || fill_reached); // RQ14
   assign stream_drop = (mode == MODE_STREAMING) && full && sample_i.valid && !pop; // RQ1
   assign push = sample_i.valid && !flush && !read_collide && !limit_block; // RQ1

   sample_store u_sample_store (
      .clock_i(clock_i),
      .rst_b_i(rst_b_i),
      .flush_i(flush),
      .push_i(push),
      .pop_i(pop || stream_drop), // RQ1
      .push_data_i(sample_i.data),
      .head_o(head),
      .count_o(count),
      .empty_o(empty),
      .full_o(full)
   );

   always_comb begin
      // Lock only outlives the level while stored samples remain, so a drain reopens it
      next_locked = 1'b0;
      if (mode == MODE_FILL_LIMITED) begin
         next_locked = fill_reached || (locked && !empty); // RQ14
      end
      next_last_sample = sample_i.valid ? sample_i.data : last_sample;
      next_was_empty = empty;
      next_was_filled = fill_reached;
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         locked <= 1'b0;
         last_sample <= '0;
         was_empty <= 1'b1;
         was_filled <= 1'b0;
      end else begin
         locked <= next_locked;
         last_sample <= next_last_sample;
         was_empty <= next_was_empty;
         was_filled <= next_was_filled;
      end
   end

   // ----------------------------------------
   // Sticky flags
   // ----------------------------------------
   always_comb begin
      set_flags = '0;
      if (!flush) begin
         set_flags[EMPTY_FLAG] = empty && !was_empty; // RQ10
         set_flags[FILL_FLAG] = fill_reached && !was_filled;
         set_flags[OVERRUN_FLAG] = stream_drop || (sample_i.valid && limit_block); // RQ2 RQ14
         set_flags[LOWER_FLAG] = lower_limit_flag_i;
         set_flags[UPPER_FLAG] = upper_limit_flag_i;
         set_flags[READ_ERR_FLAG] = sample_read && empty;
         set_flags[WRITE_ERR_FLAG] = read_collide || (sample_i.valid && limit_block);
      end
      clear_flags = '0;
      if (bus_i.wr && (bus_i.addr == FLAGS_ADDR)) begin
         clear_flags = bus_i.wdata[FLAG_W-1:0];
      end
      // Write error also drops by itself once the FIFO has drained
      clear_flags[WRITE_ERR_FLAG] = clear_flags[WRITE_ERR_FLAG] || empty; // RQ15
      // A new event in the clearing cycle survives the clear
      next_flags = (flags & ~clear_flags) | set_flags;
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         flags <= FLAGS_RESET;
      end else begin
         flags <= next_flags;
      end
   end

   // ----------------------------------------
   // Interrupt
   // ----------------------------------------
   assign enables[EMPTY_FLAG] = ctrl[EMPTY_EN_BIT]; // RQ10
   assign enables[FILL_FLAG] = ctrl[FILL_EN_BIT]; // RQ9
   assign enables[OVERRUN_FLAG] = ctrl[OVERRUN_EN_BIT]; // RQ8
   assign enables[LOWER_FLAG] = ctrl[LOWER_EN_BIT]; // RQ7
   assign enables[UPPER_FLAG] = ctrl[UPPER_EN_BIT]; // RQ6
   assign enables[READ_ERR_FLAG] = ctrl[READ_ERR_EN_BIT]; // RQ5
   assign enables[WRITE_ERR_FLAG] = ctrl[WRITE_ERR_EN_BIT]; // RQ4
   assign irq_o = |(flags & enables); // RQ16

   // ----------------------------------------
   // Register port
   // ----------------------------------------
   always_comb begin
      next_ctrl = ctrl;
      if (bus_i.wr && (bus_i.addr == CTRL_ADDR)) begin
         // Spare bit is stored as written; software is expected to keep it zero
         next_ctrl = bus_i.wdata[CTRL_RW_W-1:0]; // RQ3
      end
      next_rd_data = '0;
      if (bus_i.rd) begin
         unique case (bus_i.addr)
            CTRL_ADDR: next_rd_data = {12'h000, ctrl};
            FLAGS_ADDR: next_rd_data = {25'h0000000, flags};
            LEVEL_ADDR: next_rd_data = {23'h000000, count};
            SAMPLE_ADDR: begin
               // Off mode hands out the newest conversion; an empty read returns zero
               if (flush) begin
                  next_rd_data = {8'h00, last_sample};
               end else if (!empty) begin
                  next_rd_data = {8'h00, head};
               end
            end
            default: next_rd_data = '0;
         endcase
      end
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl <= CTRL_RESET[CTRL_RW_W-1:0]; // RQ4 RQ9
         rd_data <= '0;
      end else begin
         ctrl <= next_ctrl;
         rd_data <= next_rd_data;
      end
   end

   assign rd_data_o = rd_data;

endmodule // sample_fifo_control_irq

// [sim/sample_fifo_control_irq_assertions.sv]
// Port checker for the sample FIFO control block.
// Assumes one clock and an async active-low reset; bound to the top module.
`timescale 1ns/1ps
module sample_fifo_control_irq_assertions
   import sample_fifo_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire sample_fifo_pkg::bus_req_s bus_i,
   input wire logic [sample_fifo_pkg::DATA_W-1:0] rd_data_o,
   input wire sample_fifo_pkg::sample_s sample_i,
   input wire logic upper_limit_flag_i,
   input wire logic lower_limit_flag_i,
   input wire logic irq_o
);
   // Shadow of the stored control bits
   logic [CTRL_RW_W-1:0] ctrl;
   logic [CTRL_RW_W-1:0] next_ctrl;
   logic settled;
   always_comb begin
      next_ctrl = ctrl;
      if (bus_i.wr && bus_i.addr == CTRL_ADDR) begin
         next_ctrl = bus_i.wdata[CTRL_RW_W-1:0];
      end
   end
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ctrl <= CTRL_RESET[CTRL_RW_W-1:0];
      end else begin
         ctrl <= next_ctrl;
      end
   end
   // A write in the same cycle may drop the enable, so leave those cycles out
   assign settled = !bus_i.wr && ctrl[17:16] != MODE_OFF_CODE;
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);
   property p_ctrl_read;
      bus_i.rd && bus_i.addr == CTRL_ADDR |=> rd_data_o == {12'h0, $past(ctrl)};
   endproperty
   a_ctrl_read: assert property (p_ctrl_read) else $error("ctrl readback wrong");
   property p_no_enable;
      ctrl[14:8] == 7'h00 |-> !irq_o;
   endproperty
   a_no_enable: assert property (p_no_enable) else $error("irq with no enable");
   property p_upper_irq;
      upper_limit_flag_i && ctrl[UPPER_EN_BIT] && settled |=> irq_o;
   endproperty
   a_upper_irq: assert property (p_upper_irq) else $error("upper event lost");
   property p_lower_irq;
      lower_limit_flag_i && ctrl[LOWER_EN_BIT] && settled |=> irq_o;
   endproperty
   a_lower_irq: assert property (p_lower_irq) else $error("lower event lost");
   property p_level_max;
      bus_i.rd && bus_i.addr == LEVEL_ADDR |=> rd_data_o <= DATA_W'(DEPTH);
   endproperty
   a_level_max: assert property (p_level_max) else $error("level above depth");
   property p_off_level;
      bus_i.rd && bus_i.addr == LEVEL_ADDR && ctrl[17:16] == 2'h0
         && $past(ctrl[17:16]) == 2'h0 |=> rd_data_o == '0;
   endproperty
   a_off_level: assert property (p_off_level) else $error("off mode stored");
   property p_irq_fall;
      $fell(irq_o) |-> $past(bus_i.wr) || $past(bus_i.wr, 2) || $past(bus_i.rd)
         || $past(bus_i.rd, 2);
   endproperty
   a_irq_fall: assert property (p_irq_fall) else $error("irq fell alone");
   property p_off_quiet;
      ctrl[17:16] == MODE_OFF_CODE && !bus_i.wr && !irq_o |=> !irq_o;
   endproperty
   a_off_quiet: assert property (p_off_quiet) else $error("flag set when off");
   c_upper: cover property (upper_limit_flag_i && ctrl[UPPER_EN_BIT] ##1 irq_o);
   c_full: cover property (bus_i.rd && bus_i.addr == LEVEL_ADDR ##1 rd_data_o == DATA_W'(DEPTH));
   c_ctrl: cover property (bus_i.rd && bus_i.addr == CTRL_ADDR);
endmodule // sample_fifo_control_irq_assertions

bind sample_fifo_control_irq sample_fifo_control_irq_assertions u_sample_fifo_control_irq_assertions (
   .clock_i(clock_i), .rst_b_i(rst_b_i), .bus_i(bus_i), .rd_data_o(rd_data_o),
   .sample_i(sample_i), .upper_limit_flag_i(upper_limit_flag_i),
   .lower_limit_flag_i(lower_limit_flag_i), .irq_o(irq_o));

// [sim/conv_source.sv]
// Converter core model: one conversion pulse per cycle of go_i, data counts up.
// Assumes the bench raises go_i just after a clock edge.
`timescale 1ns/1ps
module conv_source
   import sample_fifo_pkg::*;
(
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic go_i,
   output sample_fifo_pkg::sample_s sample_o
);
   logic [SAMPLE_W-1:0] seq;
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         seq <= '0;
         sample_o <= '0;
      end else begin
         sample_o.valid <= go_i;
         // Data toggles between pulses so a stale word is never taken
         sample_o.data <= go_i ? seq : ~sample_o.data;
         if (go_i) begin
            seq <= seq + 1'b1;
         end
      end
   end
endmodule // conv_source

// [sim/sample_fifo_control_irq_test.sv]
// Register-level bench for the sample FIFO control block.
// Assumes the package constants and the conv_source model.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
   $display("wrong value %s expected %h seen %h", nm, e, g); end end
module sample_fifo_control_irq_test;
   import sample_fifo_pkg::*;
   logic clock_i, rst_b_i, go, upper, lower, irq;
   bus_req_s bus;
   sample_s smp;
   logic [DATA_W-1:0] rd_data;
   logic [6:0] f;
   int error_cnt, n_compared, sent, n;
   sample_fifo_control_irq u_sample_fifo_control_irq (.clock_i(clock_i), .rst_b_i(rst_b_i),
      .bus_i(bus), .rd_data_o(rd_data), .sample_i(smp), .upper_limit_flag_i(upper),
      .lower_limit_flag_i(lower), .irq_o(irq));
   conv_source u_conv_source (.clock_i(clock_i), .rst_b_i(rst_b_i), .go_i(go), .sample_o(smp));
   initial begin
      clock_i = 1'b0;
      forever #50 clock_i = ~clock_i;
   end
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
      @(posedge clock_i);
      bus <= '{a, v, 1'b1, 1'b0};
      @(posedge clock_i);
      bus <= '0;
   endtask
   task automatic chk_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string nm);
      @(posedge clock_i);
      bus <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge clock_i);
      bus <= '0;
      @(negedge clock_i);
      `CHK(nm, e, rd_data)
   endtask
   task automatic chk_irq(input logic e);
      @(negedge clock_i);
      `CHK("irq", e, irq)
   endtask
   task automatic push(input int k);
      repeat (k) begin
         @(posedge clock_i);
         go <= 1'b1;
      end
      @(posedge clock_i);
      go <= 1'b0;
      sent += k;
   endtask
   task automatic close_out;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      #1_000_000;
      error_cnt++;
      close_out;
   end
   initial begin
      bus = '0; go = 1'b0; upper = 1'b0; lower = 1'b0; rst_b_i = 1'b0;
      error_cnt = 0; n_compared = 0; sent = 0; f = 7'b1011110;
      repeat (12) @(posedge clock_i);
      rst_b_i <= 1'b1;
      chk_rd(CTRL_ADDR, 32'h00040200, "ctrl reset");
      push(1);
      chk_rd(LEVEL_ADDR, 32'h0, "off level");
      chk_rd(8'h00, 32'h0, "unmapped");
      $display("test reset_off done");
      wr(CTRL_ADDR, 32'h00017f04);
      wr(FLAGS_ADDR, 32'h7f);
      push(6);
      @(posedge clock_i);
      upper <= 1'b1;
      lower <= 1'b1;
      @(posedge clock_i);
      upper <= 1'b0;
      lower <= 1'b0;
      chk_rd(LEVEL_ADDR, 32'h4, "held level");
      for (int i = 0; i < FLAG_W; i++) begin
         wr(CTRL_ADDR, 32'h00010004 | (32'h100 << i));
         chk_irq(f[i]);
      end
      for (int i = 1; i < 5; i++) begin
         chk_rd(SAMPLE_ADDR, DATA_W'(i), "kept sample");
      end
      chk_rd(FLAGS_ADDR, 32'h1f, "drained flags");
      chk_rd(SAMPLE_ADDR, 32'h0, "empty read");
      push(1);
      chk_rd(LEVEL_ADDR, 32'h1, "reopened level");
      wr(CTRL_ADDR, 32'h00010100);
      chk_irq(1'b1);
      wr(CTRL_ADDR, 32'h00012000);
      chk_irq(1'b1);
      wr(CTRL_ADDR, 32'h00014000);
      chk_irq(1'b0);
      $display("test fill_limited done");
      wr(FLAGS_ADDR, 32'h7f);
      wr(CTRL_ADDR, 32'h00030000);
      n = sent;
      push(DEPTH + 1);
      chk_rd(LEVEL_ADDR, DATA_W'(DEPTH), "full level");
      chk_rd(FLAGS_ADDR, 32'h06, "stream flags");
      chk_rd(SAMPLE_ADDR, DATA_W'(n + 1), "oldest kept");
      $display("test streaming done");
      close_out;
   end
endmodule // sample_fifo_control_irq_test
